// File: logic/itsa_pkg.sv
/*
 * itsa_pkg: shared constants and types of the interrupt, tone status and
 * indirect access block.
 * Assumes a classic Wishbone slave with 32-bit data, one register per word.
 */
`default_nettype none
package itsa_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_STATUS_ONE = 8'h12;
   localparam logic [7:0] IDX_STATUS_TWO = 8'h13;
   localparam logic [7:0] IDX_STATUS_THREE = 8'h14;
   localparam logic [7:0] IDX_ENABLE_ONE = 8'h15;
   localparam logic [7:0] IDX_ENABLE_TWO = 8'h16;
   localparam logic [7:0] IDX_ENABLE_THREE = 8'h17;
   localparam logic [7:0] IDX_TONE_STATUS = 8'h18;
   localparam logic [7:0] IDX_DATA_LOW = 8'h1C;
   localparam logic [7:0] IDX_DATA_HIGH = 8'h1D;
   localparam logic [7:0] IDX_ADDRESS = 8'h1E;
   localparam logic [7:0] IDX_ACCESS_STATUS = 8'h1F;
   // ==========================================================
   // field positions and reset values
   localparam int BIT_TONE_DIGIT = 0;
   localparam int BIT_INDIRECT_DONE = 1;
   localparam int BIT_CALIB_ERROR = 2;
   localparam int BIT_DIGIT_VALID = 4;
   localparam int BIT_INDIRECT_BUSY = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] MASK_THREE = 3'h7;
   // ==========================================================
   // timing: indirect update rate
   localparam int CLK_HZ = 125000000;
   localparam int UPDATE_HZ = 16000;
   localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
   // ==========================================================
   // event sources, one pulse per event
   typedef struct packed {
      logic [7:0] timer;      // same layout as enable one
      logic [7:0] alarm;      // same layout as enable two
      logic hook_change;
      logic calib_running;
      logic tone_detect;
   } itsa_events_t;
   // decoded touch-tone digit from the detector
   typedef struct packed {
      logic valid;
      logic [3:0] code;
   } itsa_digit_t;
   // port to the indirect register storage
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } itsa_ind_req_t;
endpackage : itsa_pkg
`default_nettype wire

// File: logic/itsa_top.sv
/*
 * itsa_top: interrupt status and enables, tone digit status and the
 * 16-bit indirect register access port, behind a Wishbone slave.
 * Assumes event inputs are single-cycle pulses on clk_sys; digit status
 * and indirect read data come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - hook change during balance calibration sets calibration error flag bit 2.
// - completed indirect service request sets indirect done flag bit 1.
// - detected touch tone sets tone digit flag bit 0.
// - writing one clears a pending flag; reads show pending state.
// - enable one masks eight timer interrupts, metering down to oscillator one.
// - enable two masks power alarms six to one, loop closure, ring trip.
// - enable three masks bits 2..0; bits 7..3 read zero.
// - tone status bit 4 reads one while a digit is detected.
// - digit code in bits 3..0 uses the documented tone encoding.
// - indirect data is 16 bits over low and high byte registers.
// - data then address write stores data at next 16 kHz update.
// - address-only write loads data registers at next update.
// - read-only busy bit shows an indirect access is pending.
// - status one and two flags mirror enable bit positions, write-one clear.
module itsa_top #(
   parameter int UPDATE_PERIOD = itsa_pkg::UPDATE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire itsa_pkg::itsa_events_t events_i,
   input wire itsa_pkg::itsa_digit_t digit_i,
   output itsa_pkg::itsa_ind_req_t ind_req_o,
   output logic ind_strobe_o,
   input wire logic [15:0] ind_rdata_i
);
   // the tick counter is sixteen bits wide and needs at least two states
   if (UPDATE_PERIOD < 2 || UPDATE_PERIOD > 65536) begin : g_bad_period
      $error("UPDATE_PERIOD must lie between 2 and 65536");
   end

   // ==========================================================
   // bus decode
   logic [7:0] status_one_ff, status_two_ff;
   logic [2:0] status_three_ff;
   logic [7:0] enable_one_ff, enable_two_ff;
   logic [2:0] enable_three_ff;
   logic [15:0] indirect_data_ff;
   logic [7:0] indirect_addr_ff;
   logic indirect_busy_ff, indirect_write_ff, data_touched_ff;
   logic [4:0] tone_status_ff;
   logic [15:0] tick_cnt_ff;
   logic ack_ff, irq_ff;
   logic [31:0] rdata_ff;
   logic service;
   logic [7:0] ind_addr_ff;
   logic [15:0] ind_wdata_ff;
   logic ind_wr_ff, ind_strobe_ff;

   // true when a register at the given index is written in byte lane 0
   function automatic logic wr_hit(input logic [7:0] idx, input logic cyc,
         input logic stb, input logic we, input logic [31:0] adr,
         input logic [3:0] sel, input logic ack);
      wr_hit = cyc && stb && we && !ack && sel[0] && adr[1:0] == 2'h0 &&
         adr[31:10] == 22'h000000 && adr[9:2] == idx;
   endfunction : wr_hit

   logic req;
   assign req = wb_cyc_i && wb_stb_i && !ack_ff;

   // one-cycle answer; ack drops in the following cycle
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   // read mux; unmapped addresses answer zero
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rdata_ff <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         rdata_ff <= 32'h00000000;
         if (wb_adr_i[31:10] == 22'h000000) begin
            case (wb_adr_i[9:2])
               itsa_pkg::IDX_STATUS_ONE: rdata_ff[7:0] <= status_one_ff;
               itsa_pkg::IDX_STATUS_TWO: rdata_ff[7:0] <= status_two_ff;
               itsa_pkg::IDX_STATUS_THREE: rdata_ff[2:0] <= status_three_ff;
               itsa_pkg::IDX_ENABLE_ONE: rdata_ff[7:0] <= enable_one_ff;
               itsa_pkg::IDX_ENABLE_TWO: rdata_ff[7:0] <= enable_two_ff;
               itsa_pkg::IDX_ENABLE_THREE: rdata_ff[2:0] <= enable_three_ff;
               itsa_pkg::IDX_TONE_STATUS: rdata_ff[4:0] <= tone_status_ff;
               itsa_pkg::IDX_DATA_LOW: rdata_ff[7:0] <= indirect_data_ff[7:0];
               itsa_pkg::IDX_DATA_HIGH:
                  rdata_ff[7:0] <= indirect_data_ff[15:8];
               itsa_pkg::IDX_ADDRESS: rdata_ff[7:0] <= indirect_addr_ff;
               itsa_pkg::IDX_ACCESS_STATUS:
                  rdata_ff[itsa_pkg::BIT_INDIRECT_BUSY] <= indirect_busy_ff;
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // interrupt flags: set wins over a same-cycle clear
   // timer and alarm flags
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         status_one_ff <= itsa_pkg::RST_BYTE;
         status_two_ff <= itsa_pkg::RST_BYTE;
      end else begin
         status_one_ff <= (status_one_ff & ~(wr_hit(itsa_pkg::IDX_STATUS_ONE,
            wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, ack_ff)
            ? wb_dat_i[7:0] : 8'h00)) | events_i.timer;
         status_two_ff <= (status_two_ff & ~(wr_hit(itsa_pkg::IDX_STATUS_TWO,
            wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, ack_ff)
            ? wb_dat_i[7:0] : 8'h00)) | events_i.alarm;
      end
   end

   logic [2:0] set_three, clr_three;
   always_comb begin
      set_three = 3'h0;
      set_three[itsa_pkg::BIT_CALIB_ERROR] =
         events_i.hook_change && events_i.calib_running;
      set_three[itsa_pkg::BIT_INDIRECT_DONE] = service;
      set_three[itsa_pkg::BIT_TONE_DIGIT] = events_i.tone_detect;
      clr_three = wr_hit(itsa_pkg::IDX_STATUS_THREE, wb_cyc_i, wb_stb_i,
         wb_we_i, wb_adr_i, wb_sel_i, ack_ff) ? wb_dat_i[2:0] : 3'h0;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         status_three_ff <= 3'h0;
      end else begin
         status_three_ff <= (status_three_ff & ~clr_three) | set_three;
      end
   end

   // ==========================================================
   // enable registers
   // mask storage
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         enable_one_ff <= itsa_pkg::RST_BYTE;
         enable_two_ff <= itsa_pkg::RST_BYTE;
         enable_three_ff <= 3'h0;
      end else begin
         if (wr_hit(itsa_pkg::IDX_ENABLE_ONE, wb_cyc_i, wb_stb_i, wb_we_i,
               wb_adr_i, wb_sel_i, ack_ff)) begin
            enable_one_ff <= wb_dat_i[7:0];
         end
         if (wr_hit(itsa_pkg::IDX_ENABLE_TWO, wb_cyc_i, wb_stb_i, wb_we_i,
               wb_adr_i, wb_sel_i, ack_ff)) begin
            enable_two_ff <= wb_dat_i[7:0];
         end
         if (wr_hit(itsa_pkg::IDX_ENABLE_THREE, wb_cyc_i, wb_stb_i, wb_we_i,
               wb_adr_i, wb_sel_i, ack_ff)) begin
            enable_three_ff <= wb_dat_i[2:0] & itsa_pkg::MASK_THREE;
         end
      end
   end

   // level interrupt, registered so the output comes from a flip-flop
   // enabled pending flags
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_one_ff & enable_one_ff) |
            |(status_two_ff & enable_two_ff) |
            |(status_three_ff & enable_three_ff);
      end
   end

   // ==========================================================
   // tone digit status, sampled from the detector
   // valid bit and code passed as encoded
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tone_status_ff <= 5'h00;
      end else begin
         tone_status_ff <= {digit_i.valid, digit_i.code};
      end
   end

   // ==========================================================
   // indirect access port
   // free-running update tick at the 16 kHz rate
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tick_cnt_ff <= 16'h0000;
      end else if (tick_cnt_ff == 16'(UPDATE_PERIOD - 1)) begin
         tick_cnt_ff <= 16'h0000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
   end

   logic tick, wr_low, wr_high, wr_addr;
   assign tick = tick_cnt_ff == 16'(UPDATE_PERIOD - 1);
   assign service = tick && indirect_busy_ff;
   assign wr_low = wr_hit(itsa_pkg::IDX_DATA_LOW, wb_cyc_i, wb_stb_i,
      wb_we_i, wb_adr_i, wb_sel_i, ack_ff);
   assign wr_high = wr_hit(itsa_pkg::IDX_DATA_HIGH, wb_cyc_i, wb_stb_i,
      wb_we_i, wb_adr_i, wb_sel_i, ack_ff);
   assign wr_addr = wr_hit(itsa_pkg::IDX_ADDRESS, wb_cyc_i, wb_stb_i,
      wb_we_i, wb_adr_i, wb_sel_i, ack_ff);

   // data bytes: host writes, and read results land at the update
   // sixteen-bit data
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         indirect_data_ff <= 16'h0000;
      end else begin
         if (wr_low) begin
            indirect_data_ff[7:0] <= wb_dat_i[7:0];
         end
         if (wr_high) begin
            indirect_data_ff[15:8] <= wb_dat_i[7:0];
         end
         if (service && !indirect_write_ff && !wr_low && !wr_high) begin
            indirect_data_ff <= ind_rdata_i;
         end
      end
   end

   // address write arms a request; data written since last request
   // decides between a write and a read
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         indirect_addr_ff <= itsa_pkg::RST_BYTE;
         data_touched_ff <= 1'b0;
         indirect_write_ff <= 1'b0;
         indirect_busy_ff <= 1'b0;
      end else begin
         if (wr_addr) begin
            indirect_addr_ff <= wb_dat_i[7:0];
            indirect_write_ff <= data_touched_ff || wr_low || wr_high;
            data_touched_ff <= 1'b0;
            indirect_busy_ff <= 1'b1;
         end else begin
            if (wr_low || wr_high) begin
               data_touched_ff <= 1'b1;
            end
            if (service) begin
               indirect_busy_ff <= 1'b0;
            end
         end
      end
   end

   // strobe to indirect storage at the update tick
   // write at update
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ind_strobe_ff <= 1'b0;
         ind_wr_ff <= 1'b0;
         ind_addr_ff <= 8'h00;
         ind_wdata_ff <= 16'h0000;
      end else begin
         ind_strobe_ff <= service && indirect_write_ff;
         ind_wr_ff <= service && indirect_write_ff;
         ind_addr_ff <= indirect_addr_ff;
         ind_wdata_ff <= indirect_data_ff;
      end
   end

   // ==========================================================
   // outputs
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign irq_o = irq_ff;
   assign ind_strobe_o = ind_strobe_ff;
   assign ind_req_o = '{wr: ind_wr_ff, addr: ind_addr_ff,
      wdata: ind_wdata_ff};
endmodule : itsa_top
`default_nettype wire

// File: test/itsa_sva.sv
/* itsa_sva: port-level assertions for itsa_top, bound to every instance.
   Assumes one clock clk_sys and the synchronous active-low reset nrst. */
`timescale 1ns/1ps
`default_nettype none
module itsa_sva #(
   parameter int UPDATE_PERIOD = itsa_pkg::UPDATE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire itsa_pkg::itsa_events_t events_i,
   input wire itsa_pkg::itsa_digit_t digit_i,
   input wire itsa_pkg::itsa_ind_req_t ind_req_o,
   input wire logic ind_strobe_o,
   input wire logic [15:0] ind_rdata_i
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // bus answer: one registered ack per request, read data qualified
   chk_ack_pulse:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held high");
   chk_ack_follows:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   chk_enable_pad:
   assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 32'h5C
      |-> wb_dat_o[7:3] == 5'h00) else $error("enable three pad bits set");
   chk_status_pad:
   assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 32'h50
      |-> wb_dat_o[7:3] == 5'h00) else $error("status three pad bits set");
   chk_tone_read:
   assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 32'h60
      |-> wb_dat_o == {27'h0, $past(digit_i, 2)})
      else $error("tone status wrong");
   chk_unmapped_zero:
   assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 32'h0
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   // ==========================================================
   // indirect port and interrupt line
   chk_strobe_pulse:
   assert property (ind_strobe_o |-> ind_req_o.wr ##1 !ind_strobe_o)
      else $error("strobe malformed");
   // a clear or a mask change is the only way the line can drop
   chk_irq_fall_write:
   assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_we_i, 2))
      else $error("irq dropped without a write");
   chk_reset_quiet:
   assert property ($rose(nrst) |-> !irq_o && !wb_ack_o && !ind_strobe_o)
      else $error("outputs active after reset");
   cover property ($rose(irq_o));
   cover property (ind_strobe_o);
   cover property (wb_ack_o && $past(wb_adr_i) == 32'h60);
endmodule : itsa_sva
bind itsa_top itsa_sva #(.UPDATE_PERIOD(UPDATE_PERIOD)) itsa_sva_i (
   .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq_o(irq_o), .events_i(events_i), .digit_i(digit_i),
   .ind_req_o(ind_req_o), .ind_strobe_o(ind_strobe_o),
   .ind_rdata_i(ind_rdata_i));
`default_nettype wire

// File: test/test_itsa_top.sv
/* test_itsa_top: self-checking bench for itsa_top over Wishbone.
   Assumes the itsa_pkg package and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_itsa_top;
   localparam int UPD = 16;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [3:0] sel = 4'h0;
   logic ack;
   logic irq;
   logic strobe;
   logic [15:0] rdata_ind = 16'h0;
   itsa_pkg::itsa_events_t ev = '0;
   itsa_pkg::itsa_digit_t dig = '0;
   itsa_pkg::itsa_ind_req_t req;
   int n_errors = 0;
   int checks = 0;
   int n_strobe = 0;
   int n;
   logic [7:0] v;
   logic [3:0] codes [15] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF, 4'h0};
   logic [7:0] idxs [10] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1C,
      8'h1D, 8'h1E, 8'h1F, 8'h00};
   itsa_top #(.UPDATE_PERIOD(UPD)) itsa_top_i (.clk_sys(clk_sys),
      .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_o(irq), .events_i(ev), .digit_i(dig),
      .ind_req_o(req), .ind_strobe_o(strobe), .ind_rdata_i(rdata_ind));
   // clock, and a tally of write strobes to the indirect storage
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (strobe === 1'b1) n_strobe++;
   end
   // ==========================================================
   // bus and stimulus tasks
   task automatic xfer(input logic w, input logic [7:0] idx,
         input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= {22'h0, idx, 2'b00};
      wdat <= {24'h0, d};
      @(posedge clk_sys);
      // the slave answer time is not assumed, only bounded
      while (ack !== 1'b1 && k < 50) begin
         @(posedge clk_sys);
         k++;
      end
      if (k == 50) n_errors++;
      v = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 8'h00);
      `CHK(v, e)
   endtask : rd
   task automatic pulse(input itsa_pkg::itsa_events_t e);
      @(posedge clk_sys);
      ev <= e;
      @(posedge clk_sys);
      ev <= '0;
      repeat (3) @(posedge clk_sys);
   endtask : pulse
   // two edges let the registered line settle before it is looked at
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, e)
   endtask : irq_is
   task automatic conclude();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      conclude();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      foreach (idxs[i]) rd(idxs[i], 8'h00);
      xfer(1'b1, 8'h15, 8'hFF);
      rd(8'h15, 8'hFF);
      xfer(1'b1, 8'h16, 8'hFF);
      rd(8'h16, 8'hFF);
      xfer(1'b1, 8'h17, 8'hFF);
      rd(8'h17, 8'h07);
      $display("test registers done");
      pulse('{tone_detect: 1'b1, default: '0});
      rd(8'h14, 8'h01);
      irq_is(1'b1);
      xfer(1'b1, 8'h14, 8'h00);
      rd(8'h14, 8'h01);
      xfer(1'b1, 8'h14, 8'h01);
      rd(8'h14, 8'h00);
      irq_is(1'b0);
      pulse('{hook_change: 1'b1, default: '0});
      rd(8'h14, 8'h00);
      pulse('{hook_change: 1'b1, calib_running: 1'b1, default: '0});
      rd(8'h14, 8'h04);
      xfer(1'b1, 8'h14, 8'hFF);
      xfer(1'b1, 8'h17, 8'h06);
      pulse('{tone_detect: 1'b1, default: '0});
      irq_is(1'b0);
      xfer(1'b1, 8'h14, 8'h01);
      xfer(1'b1, 8'h15, 8'h7F);
      pulse('{timer: 8'h80, default: '0});
      rd(8'h12, 8'h80);
      irq_is(1'b0);
      xfer(1'b1, 8'h15, 8'h80);
      irq_is(1'b1);
      xfer(1'b1, 8'h12, 8'hFF);
      xfer(1'b1, 8'h16, 8'h02);
      pulse('{alarm: 8'h01, default: '0});
      rd(8'h13, 8'h01);
      irq_is(1'b0);
      pulse('{alarm: 8'h02, default: '0});
      irq_is(1'b1);
      xfer(1'b1, 8'h13, 8'hFF);
      irq_is(1'b0);
      $display("test interrupts done");
      foreach (codes[i]) begin
         @(posedge clk_sys);
         dig <= '{valid: 1'b1, code: codes[i]};
         rd(8'h18, {4'h1, codes[i]});
      end
      @(posedge clk_sys);
      dig <= '0;
      rd(8'h18, 8'h00);
      $display("test digits done");
      xfer(1'b1, 8'h1C, 8'h34);
      xfer(1'b1, 8'h1D, 8'h12);
      xfer(1'b1, 8'h1E, 8'h5A);
      n = 0;
      while (strobe !== 1'b1 && n < 4 * UPD) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK(req, {1'b1, 8'h5A, 16'h1234})
      rd(8'h1F, 8'h00);
      rd(8'h14, 8'h02);
      xfer(1'b1, 8'h14, 8'h02);
      @(posedge clk_sys);
      rdata_ind <= 16'hBEEF;
      xfer(1'b1, 8'h1E, 8'h33);
      n = 0;
      v = 8'h01;
      while (v[0] !== 1'b0 && n < 20) begin
         xfer(1'b0, 8'h1F, 8'h00);
         n++;
      end
      // the first poll lands before the update, so busy must show pending
      `CHK(n > 1, 1'b1)
      rd(8'h1C, 8'hEF);
      rd(8'h1D, 8'hBE);
      rd(8'h14, 8'h02);
      irq_is(1'b1);
      `CHK(n_strobe, 1)
      $display("test indirect done");
      conclude();
   end
endmodule : test_itsa_top
`default_nettype wire
